// ---- pkg/clk_ctl_pkg.sv ----
`default_nettype none
package clk_ctl_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] idx_soft_reset = 8'h00;
   localparam logic [7:0] idx_dll_control = 8'h52;
   localparam logic [7:0] idx_clock_source = 8'h53;
   localparam logic [7:0] idx_ref_div_low = 8'h54;
   localparam logic [7:0] idx_ref_div_high = 8'h55;
   localparam logic [7:0] idx_fb_div_low = 8'h56;
   localparam logic [7:0] idx_fb_div_high = 8'h57;
   localparam logic [7:0] idx_pump_current = 8'h58;
   localparam logic [7:0] idx_cal_trigger = 8'h6b;
   localparam logic [7:0] idx_pll_clock_en = 8'h6d;
   localparam logic [7:0] idx_status = 8'hd1;
   localparam int addr_w = 12;
   // field positions
   localparam int soft_reset_bit = 0;
   localparam int dll_reset_bit = 0;
   localparam int dll_enable_bit = 1;
   localparam int duty_enable_bit = 2;
   localparam int clock_source_bit = 0;
   localparam int cal_trigger_bit = 0;
   localparam int pll_clock_en_bit = 0;
   localparam int stat_low_bit = 0;
   localparam int stat_high_bit = 1;
   localparam int stat_cal_bit = 2;
   localparam int ref_div_high_lsb = 0;
   localparam int out_div_lsb = 4;
   // values after reset
   localparam logic [2:0] dll_control_rst = 3'h1;
   localparam logic [9:0] ref_div_rst = 10'h001;
   localparam logic [11:0] fb_div_rst = 12'h001;
   localparam logic [3:0] out_div_rst = 4'h1;
   localparam logic [3:0] pump_current_rst = 4'h4;
   // bus answers
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   // timing
   localparam int clk_period_ns = 10;
   localparam int cal_time_ns = 10000;
   localparam int cal_cycles = (cal_time_ns + clk_period_ns - 1)
      / clk_period_ns;
   localparam int dll_reset_time_ns = 100;
   localparam int dll_reset_cycles = (dll_reset_time_ns + clk_period_ns - 1)
      / clk_period_ns;

   function automatic logic [addr_w-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'h0, idx, 2'h0};
   endfunction : byte_addr
endpackage : clk_ctl_pkg
`default_nettype wire

// ---- logic/pll_cal_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_cal_sequencer #(
   parameter int CYCLES = 1000
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // control
   input wire logic start,
   // state
   output logic busy_q,
   output logic done_q
);
   localparam int cnt_w = $clog2(CYCLES + 1);

   if (CYCLES < 1) begin : g_bad_cycles
      $error("calibration length must be at least one cycle");
   end

   logic [cnt_w-1:0] cnt_q;

   // restart aborts any running calibration; done only after full count
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (start) begin
         cnt_q <= cnt_w'(CYCLES);
         busy_q <= 1'b1;
         done_q <= 1'b0;
      end else if (busy_q) begin
         if (cnt_q == cnt_w'(1)) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end
         cnt_q <= cnt_q - cnt_w'(1);
      end
   end
endmodule : pll_cal_sequencer
`default_nettype wire

// ---- logic/adc_clock_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_clock_control #(
   parameter int CAL_CYCLES = clk_ctl_pkg::cal_cycles
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // axi4-lite write address
   input wire logic [clk_ctl_pkg::addr_w-1:0] awaddr,
   input wire logic awvalid,
   output logic awready_q,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready_q,
   // axi4-lite write response
   output logic [1:0] bresp_q,
   output logic bvalid_q,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [clk_ctl_pkg::addr_w-1:0] araddr,
   input wire logic arvalid,
   output logic arready_q,
   // axi4-lite read data
   output logic [31:0] rdata_q,
   output logic [1:0] rresp_q,
   output logic rvalid_q,
   input wire logic rready,
   // oscillator status from analog
   input wire logic oscillator_low_raw,
   input wire logic oscillator_high_raw,
   // clock path control
   output logic sample_from_pll_q,
   output logic pll_clock_to_core_q,
   output logic dll_enable_q,
   output logic dll_reset_q,
   output logic duty_correction_q,
   // pll settings
   output logic [9:0] pll_reference_divider_q,
   output logic [11:0] pll_feedback_divider_q,
   output logic [3:0] pll_output_divider_q,
   output logic [3:0] pll_pump_current_q,
   // calibration
   output logic pll_calibration_start_q,
   output logic pll_calibrating_q
);
   localparam int dll_cnt_w = $clog2(clk_ctl_pkg::dll_reset_cycles + 1);

   if (CAL_CYCLES < 1) begin : g_bad_cal
      $error("calibration length must be at least one cycle");
   end

   ////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic is_mapped(input logic [11:0] a);
      unique case (a)
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_soft_reset),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_dll_control),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_clock_source),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_ref_div_low),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_ref_div_high),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_fb_div_low),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_fb_div_high),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_pump_current),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_cal_trigger),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_pll_clock_en),
         clk_ctl_pkg::byte_addr(clk_ctl_pkg::idx_status):
            is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      hit = (a == clk_ctl_pkg::byte_addr(idx));
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [11:0] awaddr_q;
   logic aw_hold_q;
   logic [7:0] wbyte_q;
   logic wlane_q, w_hold_q;
   logic [2:0] dll_control_q;
   logic clock_source_q;
   logic [9:0] ref_div_q;
   logic [11:0] fb_div_q;
   logic [3:0] out_div_q, pump_q;
   logic cal_trigger_q, pll_clock_en_q;
   logic [dll_cnt_w-1:0] dll_cnt_q;
   logic low_meta_q, low_sync_q, high_meta_q, high_sync_q;
   logic cal_busy, cal_done;
   logic do_write, wr_en, soft_reset, cal_start, dll_auto_end;

   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_en = do_write && wlane_q;
   assign soft_reset = wr_en
      && hit(awaddr_q, clk_ctl_pkg::idx_soft_reset)
      && wbyte_q[clk_ctl_pkg::soft_reset_bit];
   assign cal_start = soft_reset
      || (wr_en && hit(awaddr_q, clk_ctl_pkg::idx_cal_trigger)
      && wbyte_q[clk_ctl_pkg::cal_trigger_bit] && !cal_trigger_q);
   assign dll_auto_end = (dll_cnt_q == dll_cnt_w'(1));

   ////////////////////////////////////////////////////////////////////////
   // axi write channels
   always_ff @(posedge mclk) begin
      if (srst) begin
         awready_q <= 1'b0;
         aw_hold_q <= 1'b0;
         awaddr_q <= '0;
      end else if (awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_hold_q <= 1'b1;
         awaddr_q <= awaddr;
      end else if (do_write) begin
         aw_hold_q <= 1'b0;
      end else if (!aw_hold_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wready_q <= 1'b0;
         w_hold_q <= 1'b0;
         wbyte_q <= '0;
         wlane_q <= 1'b0;
      end else if (wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_hold_q <= 1'b1;
         wbyte_q <= wdata[7:0];
         wlane_q <= wstrb[0];
      end else if (do_write) begin
         w_hold_q <= 1'b0;
      end else if (!w_hold_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         bvalid_q <= 1'b0;
         bresp_q <= clk_ctl_pkg::resp_okay;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= is_mapped(awaddr_q) ? clk_ctl_pkg::resp_okay
            : clk_ctl_pkg::resp_slverr;
      end else if (bvalid_q && bready) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi read channels
   always_ff @(posedge mclk) begin
      if (srst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= clk_ctl_pkg::resp_okay;
      end else if (arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= {24'h0, read_mux(araddr)};
         rresp_q <= is_mapped(araddr) ? clk_ctl_pkg::resp_okay
            : clk_ctl_pkg::resp_slverr;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   function automatic logic [7:0] read_mux(input logic [11:0] a);
      read_mux = 8'h00;
      if (hit(a, clk_ctl_pkg::idx_dll_control))
         read_mux = {5'h0, dll_control_q};
      if (hit(a, clk_ctl_pkg::idx_clock_source))
         read_mux = {7'h0, clock_source_q};
      if (hit(a, clk_ctl_pkg::idx_ref_div_low))
         read_mux = ref_div_q[7:0];
      if (hit(a, clk_ctl_pkg::idx_ref_div_high))
         read_mux = {out_div_q, 2'h0, ref_div_q[9:8]};
      if (hit(a, clk_ctl_pkg::idx_fb_div_low))
         read_mux = fb_div_q[7:0];
      if (hit(a, clk_ctl_pkg::idx_fb_div_high))
         read_mux = {4'h0, fb_div_q[11:8]};
      if (hit(a, clk_ctl_pkg::idx_pump_current))
         read_mux = {4'h0, pump_q};
      if (hit(a, clk_ctl_pkg::idx_cal_trigger))
         read_mux = {7'h0, cal_trigger_q};
      if (hit(a, clk_ctl_pkg::idx_pll_clock_en))
         read_mux = {7'h0, pll_clock_en_q};
      if (hit(a, clk_ctl_pkg::idx_status))
         read_mux = {5'h0, cal_done, high_sync_q, low_sync_q};
   endfunction : read_mux

   ////////////////////////////////////////////////////////////////////////
   // control registers
   // dll control: reset bit set from power-up, cleared by auto reset end
   always_ff @(posedge mclk) begin
      if (srst) begin
         dll_control_q <= clk_ctl_pkg::dll_control_rst;
      end else if (wr_en && hit(awaddr_q, clk_ctl_pkg::idx_dll_control)) begin
         dll_control_q <= wbyte_q[2:0];
      end else if (dll_auto_end) begin
         dll_control_q[clk_ctl_pkg::dll_reset_bit] <= 1'b0;
      end
   end

   // auto reset run length after a soft reset with dll enabled
   always_ff @(posedge mclk) begin
      if (srst) begin
         dll_cnt_q <= '0;
      end else if (soft_reset
            && dll_control_q[clk_ctl_pkg::dll_enable_bit]) begin
         dll_cnt_q <= dll_cnt_w'(clk_ctl_pkg::dll_reset_cycles);
      end else if (dll_cnt_q != '0) begin
         dll_cnt_q <= dll_cnt_q - dll_cnt_w'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         clock_source_q <= 1'b0;
         pll_clock_en_q <= 1'b0;
         cal_trigger_q <= 1'b0;
      end else if (wr_en) begin
         if (hit(awaddr_q, clk_ctl_pkg::idx_clock_source))
            clock_source_q <= wbyte_q[clk_ctl_pkg::clock_source_bit];
         if (hit(awaddr_q, clk_ctl_pkg::idx_pll_clock_en))
            pll_clock_en_q <= wbyte_q[clk_ctl_pkg::pll_clock_en_bit];
         if (hit(awaddr_q, clk_ctl_pkg::idx_cal_trigger))
            cal_trigger_q <= wbyte_q[clk_ctl_pkg::cal_trigger_bit];
      end
   end

   // pll divider and pump fields
   always_ff @(posedge mclk) begin
      if (srst) begin
         ref_div_q <= clk_ctl_pkg::ref_div_rst;
         fb_div_q <= clk_ctl_pkg::fb_div_rst;
         out_div_q <= clk_ctl_pkg::out_div_rst;
         pump_q <= clk_ctl_pkg::pump_current_rst;
      end else if (wr_en) begin
         if (hit(awaddr_q, clk_ctl_pkg::idx_ref_div_low))
            ref_div_q[7:0] <= wbyte_q;
         if (hit(awaddr_q, clk_ctl_pkg::idx_ref_div_high)) begin
            ref_div_q[9:8] <= wbyte_q[clk_ctl_pkg::ref_div_high_lsb +: 2];
            out_div_q <= wbyte_q[clk_ctl_pkg::out_div_lsb +: 4];
         end
         if (hit(awaddr_q, clk_ctl_pkg::idx_fb_div_low))
            fb_div_q[7:0] <= wbyte_q;
         if (hit(awaddr_q, clk_ctl_pkg::idx_fb_div_high))
            fb_div_q[11:8] <= wbyte_q[3:0];
         if (hit(awaddr_q, clk_ctl_pkg::idx_pump_current))
            pump_q <= wbyte_q[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator status synchronisers
   always_ff @(posedge mclk) begin
      if (srst) begin
         low_meta_q <= 1'b0;
         low_sync_q <= 1'b0;
         high_meta_q <= 1'b0;
         high_sync_q <= 1'b0;
      end else begin
         low_meta_q <= oscillator_low_raw;
         low_sync_q <= low_meta_q;
         high_meta_q <= oscillator_high_raw;
         high_sync_q <= high_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // calibration
   pll_cal_sequencer #(
      .CYCLES(CAL_CYCLES)
   ) u_cal (
      .mclk(mclk),
      .srst(srst),
      .start(cal_start),
      .busy_q(cal_busy),
      .done_q(cal_done)
   );

   always_ff @(posedge mclk) begin
      if (srst) begin
         pll_calibration_start_q <= 1'b0;
         pll_calibrating_q <= 1'b0;
      end else begin
         pll_calibration_start_q <= cal_start;
         pll_calibrating_q <= cal_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock path outputs
   always_ff @(posedge mclk) begin
      if (srst) begin
         sample_from_pll_q <= 1'b0;
         pll_clock_to_core_q <= 1'b0;
         dll_enable_q <= 1'b0;
         dll_reset_q <= 1'b1;
         duty_correction_q <= 1'b0;
      end else begin
         sample_from_pll_q <= clock_source_q;
         pll_clock_to_core_q <= clock_source_q && pll_clock_en_q;
         dll_enable_q <= dll_control_q[clk_ctl_pkg::dll_enable_bit];
         dll_reset_q <= dll_control_q[clk_ctl_pkg::dll_reset_bit]
            || (dll_cnt_q != '0);
         // falling-edge-only trim, dll path only
         duty_correction_q <= dll_control_q[clk_ctl_pkg::duty_enable_bit]
            && dll_control_q[clk_ctl_pkg::dll_enable_bit]
            && !clock_source_q;
      end
   end

   // zero divider codes are steered to one
   always_ff @(posedge mclk) begin
      if (srst) begin
         pll_reference_divider_q <= clk_ctl_pkg::ref_div_rst;
         pll_feedback_divider_q <= clk_ctl_pkg::fb_div_rst;
         pll_output_divider_q <= clk_ctl_pkg::out_div_rst;
         pll_pump_current_q <= clk_ctl_pkg::pump_current_rst;
      end else begin
         pll_reference_divider_q <= (ref_div_q == '0) ? 10'h001
            : ref_div_q;
         pll_feedback_divider_q <= (fb_div_q == '0) ? 12'h001
            : fb_div_q;
         pll_output_divider_q <= (out_div_q == '0) ? 4'h1
            : out_div_q;
         pll_pump_current_q <= pump_q;
      end
   end
endmodule : adc_clock_control
`default_nettype wire

// ---- tb/adc_clock_control_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_clock_control_chk #(
   parameter int CAL_CYCLES = clk_ctl_pkg::cal_cycles
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // clock path
   input wire logic sample_from_pll_q,
   input wire logic pll_clock_to_core_q,
   input wire logic dll_enable_q,
   input wire logic dll_reset_q,
   input wire logic duty_correction_q,
   // pll settings
   input wire logic [9:0] pll_reference_divider_q,
   input wire logic [11:0] pll_feedback_divider_q,
   input wire logic [3:0] pll_output_divider_q,
   input wire logic [3:0] pll_pump_current_q,
   // calibration
   input wire logic pll_calibration_start_q,
   input wire logic pll_calibrating_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////
   // cycles of calibration since the last start
   logic [31:0] cnt_q;
   always_ff @(posedge mclk) begin
      if (srst || pll_calibration_start_q)
         cnt_q <= 32'h0;
      else
         cnt_q <= cnt_q + {31'h0, pll_calibrating_q};
   end
   ////////////////////////////////////////////////////////////
   chk_core_gate: assert property (
      pll_clock_to_core_q |-> sample_from_pll_q)
      else $error("pll clock reaches core without pll source");
   chk_duty_gating: assert property (
      duty_correction_q |-> dll_enable_q && !sample_from_pll_q)
      else $error("duty correction active outside dll path");
   chk_reset_values: assert property (
      $fell(srst) |-> dll_reset_q
         && pll_pump_current_q == clk_ctl_pkg::pump_current_rst)
      else $error("wrong values after reset");
   chk_ref_nonzero: assert property (
      pll_reference_divider_q != 10'h000)
      else $error("reference divider is zero");
   chk_fb_nonzero: assert property (
      pll_feedback_divider_q != 12'h000)
      else $error("feedback divider is zero");
   chk_out_nonzero: assert property (
      pll_output_divider_q != 4'h0)
      else $error("output divider is zero");
   chk_start_pulse: assert property (
      pll_calibration_start_q |=> !pll_calibration_start_q)
      else $error("calibration start longer than one cycle");
   chk_cal_follows: assert property (
      pll_calibration_start_q |-> ##[0:2] pll_calibrating_q)
      else $error("calibration did not run after start");
   chk_cal_length: assert property (
      $fell(pll_calibrating_q) |-> cnt_q + 2 >= CAL_CYCLES
         && cnt_q <= CAL_CYCLES + 2)
      else $error("calibration length wrong");
   cover property (pll_calibration_start_q);
   cover property ($fell(pll_calibrating_q));
   cover property (duty_correction_q);
endmodule : adc_clock_control_chk

bind adc_clock_control adc_clock_control_chk #(
   .CAL_CYCLES(CAL_CYCLES)
) i_chk (
   .mclk(mclk), .srst(srst), .sample_from_pll_q(sample_from_pll_q),
   .pll_clock_to_core_q(pll_clock_to_core_q), .dll_enable_q(dll_enable_q),
   .dll_reset_q(dll_reset_q), .duty_correction_q(duty_correction_q),
   .pll_reference_divider_q(pll_reference_divider_q),
   .pll_feedback_divider_q(pll_feedback_divider_q),
   .pll_output_divider_q(pll_output_divider_q),
   .pll_pump_current_q(pll_pump_current_q),
   .pll_calibration_start_q(pll_calibration_start_q),
   .pll_calibrating_q(pll_calibrating_q));
`default_nettype wire

// ---- tb/ref_clock_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ref_clock_model #(
   parameter int REF_MHZ = 100,
   parameter int LOW_MHZ = 1075,
   parameter int HIGH_MHZ = 1325
) (
   // clock
   input wire logic mclk,
   // divider settings
   input wire logic [9:0] pll_reference_divider_q,
   input wire logic [11:0] pll_feedback_divider_q,
   // oscillator status
   output logic oscillator_low_raw = 1'b1,
   output logic oscillator_high_raw = 1'b0
);
   ////////////////////////////////////////////////////////////
   // oscillator frequency against tuning range
   always @(posedge mclk) begin
      oscillator_low_raw <= pll_feedback_divider_q * REF_MHZ
         < LOW_MHZ * pll_reference_divider_q;
      oscillator_high_raw <= pll_feedback_divider_q * REF_MHZ
         > HIGH_MHZ * pll_reference_divider_q;
   end
endmodule : ref_clock_model
`default_nettype wire

// ---- tb/test_adc_clock_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_adc_clock_control;
   localparam int CAL = 20;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic osc_low, osc_high, from_pll, to_core, dll_en, dll_rst, duty;
   logic cal_start, calibrating;
   logic [9:0] ref_div, r;
   logic [11:0] fb_div, f;
   logic [3:0] out_div, pump, o, p;
   int n_errors = 0, comparisons = 0, n_starts = 0, n_dll = 0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [9:0] ref_s = 10'h1;
   logic [11:0] fb_s = 12'h1;
   logic cal_s = 1'b0;
   always #5 mclk = ~mclk;
   adc_clock_control #(.CAL_CYCLES(CAL)) i_dut (
      .mclk(mclk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
      .awready_q(awready_q), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready_q(wready_q), .bresp_q(bresp_q), .bvalid_q(bvalid_q),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready_q(arready_q), .rdata_q(rdata_q), .rresp_q(rresp_q),
      .rvalid_q(rvalid_q), .rready(rready), .oscillator_low_raw(osc_low),
      .oscillator_high_raw(osc_high), .sample_from_pll_q(from_pll),
      .pll_clock_to_core_q(to_core), .dll_enable_q(dll_en),
      .dll_reset_q(dll_rst), .duty_correction_q(duty),
      .pll_reference_divider_q(ref_div), .pll_feedback_divider_q(fb_div),
      .pll_output_divider_q(out_div), .pll_pump_current_q(pump),
      .pll_calibration_start_q(cal_start), .pll_calibrating_q(calibrating));
   ref_clock_model i_ref (
      .mclk(mclk), .pll_reference_divider_q(ref_div),
      .pll_feedback_divider_q(fb_div), .oscillator_low_raw(osc_low),
      .oscillator_high_raw(osc_high));
   ////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic check(input string nm, input logic [33:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic wr(input logic [9:0] idx, input logic [7:0] d,
         input logic [3:0] s = 4'h1, input logic [1:0] er = 2'h0);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      bq.push_back(er);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(posedge mclk);
         if (awready_q === 1'b1)
            awvalid <= 1'b0;
         if (wready_q === 1'b1)
            wvalid <= 1'b0;
         a |= awready_q === 1'b1;
         w |= wready_q === 1'b1;
      end
      do @(posedge mclk); while (bvalid_q !== 1'b1);
      bready <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [9:0] idx, input logic [7:0] e,
         input logic [1:0] er = 2'h0);
      rq.push_back({er, 24'h0, e});
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (arready_q !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk); while (rvalid_q !== 1'b1);
      rready <= 1'b0;
      @(posedge mclk);
   endtask : rd
   task automatic wait_cal();
      repeat (4 * CAL) if (calibrating === 1'b1) @(posedge mclk);
      check("calibrating", calibrating, 0);
      cal_s = 1'b1;
   endtask : wait_cal
   function automatic logic [7:0] st();
      st = {5'h0, cal_s, fb_s * 100 > 1325 * ref_s, fb_s * 100 < 1075 * ref_s};
   endfunction : st
   ////////////////////////////////////////////////////////////
   // answers taken off the queues in order
   always @(posedge mclk) begin
      if (cal_start === 1'b1)
         n_starts++;
      if (dll_rst === 1'b1)
         n_dll++;
      if (bvalid_q === 1'b1 && bready)
         check("bresp", bresp_q, bq.pop_front());
      if (rvalid_q === 1'b1 && rready)
         check("rdata", {rresp_q, rdata_q}, rq.pop_front());
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h0346));
      tick(20);
      srst <= 1'b0;
      tick(1);
      check("dll_rst", dll_rst, 1);
      rd(clk_ctl_pkg::idx_dll_control, 8'h01);
      rd(clk_ctl_pkg::idx_pump_current, 8'h04);
      rd(clk_ctl_pkg::idx_status, st());
      rd(10'h010, 8'h00, clk_ctl_pkg::resp_slverr);
      wr(10'h010, 8'hff, 4'h1, clk_ctl_pkg::resp_slverr);
      wr(clk_ctl_pkg::idx_status, 8'hff);
      wr(clk_ctl_pkg::idx_clock_source, 8'h01);
      tick(1);
      check("src", {from_pll, to_core}, 2'b10);
      wr(clk_ctl_pkg::idx_pll_clock_en, 8'h01);
      tick(1);
      check("to_core", to_core, 1);
      wr(clk_ctl_pkg::idx_clock_source, 8'h00);
      tick(1);
      check("src", {from_pll, to_core}, 2'b00);
      wr(clk_ctl_pkg::idx_dll_control, 8'h06);
      tick(1);
      check("dll", {dll_en, dll_rst, duty}, 3'b101);
      wr(clk_ctl_pkg::idx_dll_control, 8'h00, 4'h0);
      rd(clk_ctl_pkg::idx_dll_control, 8'h06);
      wr(clk_ctl_pkg::idx_clock_source, 8'h01);
      tick(1);
      check("duty", duty, 0);
      wr(clk_ctl_pkg::idx_clock_source, 8'h00);
      wr(clk_ctl_pkg::idx_dll_control, 8'h05);
      tick(1);
      check("dll", {dll_en, dll_rst, duty}, 3'b010);
      wr(clk_ctl_pkg::idx_dll_control, 8'h06);
      // divider corners, status table, then random settings
      for (int i = 0; i < 8; i++) begin
         r = i == 0 ? 10'h3ff : i == 1 ? 10'h0 : 10'($urandom);
         f = i == 0 ? 12'hfff : i == 1 ? 12'h0 : 12'($urandom);
         if (i >= 2 && i <= 4) begin
            r = 10'd10;
            f = 12'(20 * i + 60);
         end
         o = 4'($urandom);
         p = 4'($urandom);
         wr(clk_ctl_pkg::idx_ref_div_low, r[7:0]);
         wr(clk_ctl_pkg::idx_ref_div_high, {o, 2'h0, r[9:8]});
         wr(clk_ctl_pkg::idx_fb_div_low, f[7:0]);
         wr(clk_ctl_pkg::idx_fb_div_high, {4'h0, f[11:8]});
         wr(clk_ctl_pkg::idx_pump_current, {4'h0, p});
         ref_s = r == 10'h0 ? 10'h1 : r;
         fb_s = f == 12'h0 ? 12'h1 : f;
         tick(4);
         check("ref", ref_div, ref_s);
         check("fb", fb_div, fb_s);
         check("out", out_div, o == 4'h0 ? 4'h1 : o);
         check("pump", pump, p);
         rd(clk_ctl_pkg::idx_ref_div_high, {o, 2'h0, r[9:8]});
         rd(clk_ctl_pkg::idx_status, st());
      end
      n_starts = 0;
      wr(clk_ctl_pkg::idx_cal_trigger, 8'h01);
      rd(clk_ctl_pkg::idx_status, st());
      wait_cal();
      rd(clk_ctl_pkg::idx_status, st());
      wr(clk_ctl_pkg::idx_cal_trigger, 8'h01);
      wr(clk_ctl_pkg::idx_cal_trigger, 8'h00);
      tick(2);
      check("starts", n_starts, 1);
      wr(clk_ctl_pkg::idx_cal_trigger, 8'h01);
      tick(2);
      check("starts", n_starts, 2);
      cal_s = 1'b0;
      rd(clk_ctl_pkg::idx_status, st());
      wait_cal();
      n_dll = 0;
      wr(clk_ctl_pkg::idx_soft_reset, 8'h01);
      tick(30);
      check("dll_pulse", n_dll, clk_ctl_pkg::dll_reset_cycles);
      check("starts", n_starts, 3);
      rd(clk_ctl_pkg::idx_dll_control, 8'h06);
      rd(clk_ctl_pkg::idx_soft_reset, 8'h00);
      rd(clk_ctl_pkg::idx_status, st());
      // auto reset must also clear a reset bit that software left set
      wr(clk_ctl_pkg::idx_dll_control, 8'h07);
      wr(clk_ctl_pkg::idx_soft_reset, 8'h01);
      tick(30);
      rd(clk_ctl_pkg::idx_dll_control, 8'h06);
      print_verdict();
   end
endmodule : test_adc_clock_control
`default_nettype wire
